/* File: shared/rspc_pkg.sv */
package rspc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] RSPC_OFF_POWER_CONTROL = 16'h1930;
    localparam logic [15:0] RSPC_OFF_WAKE_STATUS   = 16'h1934;
    localparam logic [31:0] RSPC_POWER_CONTROL_RST = 32'h0000_0018;
    localparam logic [31:0] RSPC_POWER_CONTROL_MSK = 32'h0000_001F;

    // Field positions
    localparam int RSPC_BIT_CLOCK_OUT_ENABLE       = 0;
    localparam int RSPC_BIT_REGULATOR_POWER_DOWN   = 1;
    localparam int RSPC_BIT_FULL_POWER_DOWN        = 2;
    localparam int RSPC_BIT_WAKE_PIN_DIRECTION     = 3;
    localparam int RSPC_BIT_WAKE_PIN_OUTPUT_LEVEL  = 4;

    // AXI responses
    localparam logic [1:0] RSPC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] RSPC_RESP_SLVERR = 2'b10;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic        clock_out_enable;
        logic        regulators_on;
        logic        por_comparator_on;
        logic        bandgap_on;
    } rspc_power_t;

    typedef struct packed {
        logic        wake_pin_o;
        logic        wake_pin_oe;
    } rspc_pin_t;

endpackage : rspc_pkg

/* File: verilog/rspc_power_control.sv */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
// Functional notes
// [RULE_01] Output level 0 drives wake pin low; 1 releases it to high impedance.
// [RULE_02] Direction bit 0 makes wake pin input; 1 makes it output.
// [RULE_03] Wake pin input active high; output open-drain active low, pulled up outside.
// [RULE_04] Full power-down bit 2 shuts regulators, reset comparator and bandgap.
// [RULE_05] After full power-down only wake pin high, alarm or periodic event restores.
// [RULE_06] Regulator power-down bit 1 shuts regulators and comparator; bandgap stays on.
// [RULE_07] After regulator power-down same three wake sources restore regulators and comparator.
// [RULE_08] Software avoids power-down bits while internal regulators are bypassed.
// [RULE_09] Clock-out enable bit 0 enables clock output pin when set.
// [RULE_10] Bits 15 to 5 read zero; power-down sampled synchronously in clock domain.
module rspc_power_control (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [15:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [15:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 wake_pin_i,
    input  wire logic                 alarm_wake,
    input  wire logic                 periodic_wake,
    output rspc_pkg::rspc_pin_t       wake_pin,
    output rspc_pkg::rspc_power_t     power
);
    import rspc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] awaddr;
        logic        aw_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        w_held;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [4:0]  ctrl;
        logic        full_down;
        logic        reg_down;
        logic        wake_s1;
        logic        wake_s2;
        logic        alarm_s1;
        logic        alarm_s2;
        logic        period_s1;
        logic        period_s2;
        logic        last_wake;
        rspc_power_t pwr;
        rspc_pin_t   pin;
    } rspc_state_t;

    rspc_state_t s_q;
    rspc_state_t s_d;
    logic        wake_req;
    logic        do_write;

    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rdata   = s_q.rdata;
    assign wake_pin      = s_q.pin;
    assign power         = s_q.pwr;

    // Wake pin request only seen on an input-configured pin; alarm and periodic always count
    assign wake_req = (s_q.wake_s2 && !s_q.ctrl[RSPC_BIT_WAKE_PIN_DIRECTION])
                      || s_q.alarm_s2 || s_q.period_s2;      // see [RULE_03]
    assign do_write = (s_q.aw_held || s_axi_awvalid) && (s_q.w_held || s_axi_wvalid) && !s_q.bvalid;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        // ****************************************************************
        // Input synchronisers, two flops per outside input
        // ****************************************************************
        s_d.wake_s1   = wake_pin_i;
        s_d.wake_s2   = s_q.wake_s1;
        s_d.alarm_s1  = alarm_wake;
        s_d.alarm_s2  = s_q.alarm_s1;
        s_d.period_s1 = periodic_wake;
        s_d.period_s2 = s_q.period_s1;
        s_d.last_wake = wake_req;

        // ****************************************************************
        // Write channels, address and data in either order
        // ****************************************************************
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.awaddr  = s_axi_awaddr;
            s_d.aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
            s_d.w_held = 1'b1;
        end
        if (do_write)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RSPC_RESP_OKAY;
            if ((s_q.aw_held ? s_q.awaddr : s_axi_awaddr) == RSPC_OFF_POWER_CONTROL)
            begin
                if (s_q.w_held ? s_q.wstrb[0] : s_axi_wstrb[0])
                begin
                    s_d.ctrl = s_q.w_held ? s_q.wdata[4:0] : s_axi_wdata[4:0];   // see [RULE_10]
                end
            end
            else if ((s_q.aw_held ? s_q.awaddr : s_axi_awaddr) != RSPC_OFF_WAKE_STATUS)
            begin
                s_d.bresp = RSPC_RESP_SLVERR;
            end
        end
        else if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // ****************************************************************
        // Read channel
        // ****************************************************************
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RSPC_RESP_OKAY;
            if (s_axi_araddr == RSPC_OFF_POWER_CONTROL)
            begin
                s_d.rdata = {27'h000_0000, s_q.ctrl};   // see [RULE_10]
            end
            else if (s_axi_araddr == RSPC_OFF_WAKE_STATUS)
            begin
                s_d.rdata = {26'h000_0000, s_q.pwr.bandgap_on, s_q.pwr.regulators_on,
                             s_q.full_down, s_q.reg_down, wake_req, s_q.wake_s2};
            end
            else
            begin
                s_d.rdata = 32'h0000_0000;
                s_d.rresp = RSPC_RESP_SLVERR;
            end
        end
        else if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end

        // ****************************************************************
        // Power-down latches, sampled on this clock
        // ****************************************************************
        if (s_q.ctrl[RSPC_BIT_FULL_POWER_DOWN])
        begin
            s_d.full_down = 1'b1;                       // see [RULE_04] see [RULE_10]
        end
        if (s_q.ctrl[RSPC_BIT_REGULATOR_POWER_DOWN])
        begin
            s_d.reg_down = 1'b1;                        // see [RULE_06]
        end

        // ****************************************************************
        // Rising wake request ends power-down and clears request bits
        // ****************************************************************
        // Wake edge overrides a latch set in the same cycle
        if (wake_req && !s_q.last_wake)
        begin
            s_d.full_down = 1'b0;                       // see [RULE_05]
            s_d.reg_down  = 1'b0;                       // see [RULE_07]
            s_d.ctrl[RSPC_BIT_FULL_POWER_DOWN]      = 1'b0;
            s_d.ctrl[RSPC_BIT_REGULATOR_POWER_DOWN] = 1'b0;
        end

        // ****************************************************************
        // Supply enables
        // ****************************************************************
        s_d.pwr.regulators_on     = !(s_d.full_down || s_d.reg_down);   // see [RULE_04] see [RULE_06]
        s_d.pwr.por_comparator_on = !(s_d.full_down || s_d.reg_down);
        s_d.pwr.bandgap_on        = !s_d.full_down;                     // see [RULE_06]
        s_d.pwr.clock_out_enable  = s_d.ctrl[RSPC_BIT_CLOCK_OUT_ENABLE]; // see [RULE_09]

        // ****************************************************************
        // Open-drain wake pin: only ever drives low
        // ****************************************************************
        s_d.pin.wake_pin_o  = 1'b0;                                      // see [RULE_03]
        s_d.pin.wake_pin_oe = s_d.ctrl[RSPC_BIT_WAKE_PIN_DIRECTION]
                              && !s_d.ctrl[RSPC_BIT_WAKE_PIN_OUTPUT_LEVEL]; // see [RULE_01] see [RULE_02]
    end

    // ****************************************************************
    // Register stage
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q      <= '0;
            s_q.ctrl <= RSPC_POWER_CONTROL_RST[4:0];
            s_q.pwr  <= 4'b0111;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : rspc_power_control

/* File: testbench/rspc_power_control_assertions.sv */
`timescale 1ns/10ps
module rspc_power_control_chk (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid,
    input wire logic s_axi_arvalid, s_axi_rvalid, wake_pin_i, alarm_wake, periodic_wake,
    input wire logic [31:0] s_axi_rdata,
    input wire rspc_pkg::rspc_pin_t wake_pin,
    input wire rspc_pkg::rspc_power_t power
);
    import rspc_pkg::*;
    // ******
    // Checks
    // ******
    logic [3:0] quiet_q, quiet_d;
    always_comb quiet_d = (wake_pin_i | alarm_wake | periodic_wake) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    always_ff @(posedge aclk) quiet_q <= !aresetn ? 4'hF : quiet_d;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_open_drain: assert property (wake_pin.wake_pin_o == 1'b0)
        else $error("wake pin driven high");
    chk_full_off: assert property (!power.bandgap_on |-> !power.regulators_on && !power.por_comparator_on)
        else $error("bandgap off with regulators on");
    chk_por_pair: assert property (power.regulators_on == power.por_comparator_on)
        else $error("comparator apart from regulators");
    chk_wake_cause: assert property ($rose(power.regulators_on) || $rose(power.bandgap_on) |-> quiet_q < 4'h8)
        else $error("power restored without wake");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write not answered");
    chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    chk_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
        else $error("reserved bits set");
    chk_oe_cause: assert property ($changed(wake_pin.wake_pin_oe) |-> s_axi_bvalid)
        else $error("pin driver moved without write");
    cover property ($fell(power.bandgap_on));
    cover property ($fell(power.regulators_on) && power.bandgap_on);
    cover property ($rose(wake_pin.wake_pin_oe));
endmodule : rspc_power_control_chk
bind rspc_power_control rspc_power_control_chk i_rspc_power_control_chk (.*);

/* File: testbench/rspc_wake_line.sv */
`timescale 1ns/10ps
module rspc_wake_line (
    input  wire logic                ext_low,
    input  wire rspc_pkg::rspc_pin_t wake_pin,
    output logic                     level
);
    import rspc_pkg::*;
    // Pull-up holds the line high unless either party pulls it low
    assign level = !(wake_pin.wake_pin_oe || ext_low);
endmodule : rspc_wake_line

/* File: testbench/tb_rspc_power_control.sv */
`timescale 1ns/10ps
module tb_rspc_power_control;
    import rspc_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, alarm_wake = 0, periodic_wake = 0, ext_low = 1, wake_pin_i;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    rspc_pin_t wake_pin;
    rspc_power_t power;
    int bad_count = 0, samples_checked = 0;
    rspc_power_control i_rspc_power_control (.*);
    rspc_wake_line i_rspc_wake_line (.ext_low(ext_low), .wake_pin(wake_pin), .level(wake_pin_i));
    // *********
    // Sequences
    // *********
    initial forever #2 aclk = ~aclk;
    initial
    begin
        #40000;
        bad_count++;
        test_done;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [31:0] d);
        logic pa = 1, pw = 1;
        s_axi_awaddr <= RSPC_OFF_POWER_CONTROL;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (pa || pw)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("bresp", 32'(s_axi_bresp), 32'(RSPC_RESP_OKAY));
        repeat (3) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask : rd
    task automatic t_pin;
        ext_low <= 0;
        rd(RSPC_OFF_POWER_CONTROL, RSPC_POWER_CONTROL_RST, RSPC_RESP_OKAY);
        chk("power", 32'(power), 32'h7);
        wr(32'hFFFF_FFF9);
        rd(RSPC_OFF_POWER_CONTROL, 32'h19, RSPC_RESP_OKAY);
        chk("clkout", 32'(power), 32'hF);
        chk("line", 32'(wake_pin_i), 32'h1);
        wr(32'h0000_0008);
        chk("line", 32'(wake_pin_i), 32'h0);
        chk("oe", 32'(wake_pin.wake_pin_oe), 32'h1);
        chk("clkoff", 32'(power), 32'h7);
        ext_low <= 1;
        rd(16'h1938, 32'h0, RSPC_RESP_SLVERR);
    endtask : t_pin
    task automatic t_down(input logic [31:0] cmd, input logic [3:0] off, input int src);
        wr(cmd);
        repeat (10) @(posedge aclk);
        chk("down", 32'(power), 32'(off));
        chk("oe", 32'(wake_pin.wake_pin_oe), 32'h0);
        rd(RSPC_OFF_WAKE_STATUS, 32'({off[0], off[2], cmd[2], cmd[1], 2'b00}), RSPC_RESP_OKAY);
        if (src == 0) ext_low <= 0;
        if (src == 1) alarm_wake <= 1;
        if (src == 2) periodic_wake <= 1;
        repeat (2) @(posedge aclk);
        alarm_wake <= 0;
        periodic_wake <= 0;
        repeat (8) @(posedge aclk);
        chk("wake", 32'(power), 32'h7);
        rd(RSPC_OFF_POWER_CONTROL, 32'h0, RSPC_RESP_OKAY);
        ext_low <= 1;
        repeat (4) @(posedge aclk);
    endtask : t_down
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_pin;
        // Regulators are never bypassed here, so power-down use is legal
        for (int s = 0; s < 3; s++)
        begin
            t_down(32'h0000_0002, 4'h1, s);
            t_down(32'h0000_0004, 4'h0, s);
        end
        test_done;
    end
endmodule : tb_rspc_power_control
